/* File: design/acc_ctrl.sv */
// conversion cycle control and two-wire serial slave of a delta-sigma converter
// assumes the analog front end hands over a sign/magnitude code and range flags
// on clk, and the three-level address sense arrives as a 2-bit level code
//
// Function
// RULE1 - slave only, serial clock is input
// RULE2 - sample on clock rise, update on fall
// RULE3 - release data when receiving, open-drain low
// RULE4 - three-level pin gives address bits
// RULE5 - quiet dual pin: high versus floating bit
// RULE6 - external clock used, null ratio, bit high
// RULE7 - cycle conversion, sleep, data in/out
// RULE8 - sleep until addressed, result held
// RULE9 - no acknowledge while converting
// RULE10 - read gives sign, magnitude, configuration readback
// RULE11 - result is from latest conversion
// RULE12 - write takes one configuration byte
// RULE13 - stop after write or full read converts
// RULE14 - detect start and stop conditions
// RULE15 - repeated start treated as start
// RULE16 - eight data bits plus acknowledge
// RULE17 - transmitter releases, receiver pulls for acknowledge
// RULE18 - data changes only while clock low
// RULE19 - standard and fast mode rates supported
// RULE20 - distinct overrange and underrange codes
// RULE21 - configuration byte field layout
// RULE22 - power-up defaults until valid write
// RULE23 - conversion length by speed mode
// RULE24 - address match, then read or write
// RULE25 - synchronize lines before edge detection
`include "acc_map.svh"

module acc_ctrl #(
   parameter logic [15:0] CONV_1X_TICKS = `ACC_CONV_1X,
   parameter logic [15:0] CONV_2X_TICKS = `ACC_CONV_2X,
   parameter logic [7:0] INT_TICK_DIV = 8'(`ACC_INT_TICK_DIV),
   parameter logic [11:0] EXT_WIN_CYC = 12'(`ACC_EXT_WIN_CYC),
   parameter logic [6:0] ADDR_BASE = `ACC_ADDR_BASE,
   parameter int FIFO_WIDTH = 8,
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // serial bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b,
   // address and clock pins
   input wire logic [1:0] addr_sel_tristate_pin,
   input wire logic addr_sel_or_ext_clock_pin,
   input wire logic addr_sel_or_ext_clock_float,
   // analog front end
   input wire logic [16:0] adc_code,
   input wire logic adc_over,
   input wire logic adc_under,
   // status and configuration
   output logic conv_active,
   output logic sleep_active,
   output logic ext_clk_active,
   output logic filt_tick,
   output logic [15:0] ext_null_div,
   output logic [2:0] gain_sel,
   output logic temp_input_select,
   output logic reject_mode_hi,
   output logic reject_mode_lo,
   output logic double_rate_select
);

   localparam int I_SCL = 5;
   localparam int I_SDA = 4;
   localparam int I_DUAL = 3;
   localparam int I_FLT = 2;

   // ==========================================================
   // pin synchronisers
   logic [5:0] s1_q;
   logic [5:0] s2_q;
   logic [5:0] s3_q;
   logic [5:0] lvl_q;
   logic [5:0] lvl_p_q;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_q <= `ACC_SYNC_RST;
         s2_q <= `ACC_SYNC_RST;
         s3_q <= `ACC_SYNC_RST;
         lvl_q <= `ACC_SYNC_RST;
         lvl_p_q <= `ACC_SYNC_RST;
      end
      else
      begin
         s1_q <= {scl_in, sda_in, addr_sel_or_ext_clock_pin, addr_sel_or_ext_clock_float,
                  addr_sel_tristate_pin};
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a level only counts once two stages agree
         lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q)); // RULE25
         lvl_p_q <= lvl_q;
      end
   end

   // serial clock is only ever observed, never driven
   assign scl = lvl_q[I_SCL]; // RULE1
   assign sda = lvl_q[I_SDA];
   assign scl_rise = scl & ~lvl_p_q[I_SCL]; // RULE19
   assign scl_fall = ~scl & lvl_p_q[I_SCL];
   assign start_ev = scl & lvl_p_q[I_SCL] & lvl_p_q[I_SDA] & ~sda; // RULE14 RULE15
   assign stop_ev = scl & lvl_p_q[I_SCL] & ~lvl_p_q[I_SDA] & sda; // RULE14

   // ==========================================================
   // external clock detection and conversion tick
   logic [11:0] gap_q;
   logic ext_act_q;
   logic [7:0] div_q;
   logic int_tick;
   logic conv_tick;
   logic dual_edge;

   assign dual_edge = lvl_q[I_DUAL] ^ lvl_p_q[I_DUAL];
   assign int_tick = (div_q == INT_TICK_DIV - 8'h01);
   assign conv_tick = ext_act_q ? (dual_edge & lvl_q[I_DUAL]) : int_tick; // RULE6

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gap_q <= 12'(`ACC_EXT_WIN_CYC);
         ext_act_q <= 1'b0;
      end
      else if (dual_edge)
      begin
         gap_q <= 12'h000;
         if (gap_q < EXT_WIN_CYC)
         begin
            ext_act_q <= 1'b1; // RULE6
         end
      end
      else if (gap_q >= EXT_WIN_CYC)
      begin
         ext_act_q <= 1'b0; // RULE5
      end
      else
      begin
         gap_q <= gap_q + 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_q <= 8'h00;
         filt_tick <= 1'b0;
         ext_clk_active <= 1'b0;
         ext_null_div <= 16'h0000;
      end
      else
      begin
         div_q <= int_tick ? 8'h00 : div_q + 8'h01;
         filt_tick <= conv_tick;
         ext_clk_active <= ext_act_q;
         ext_null_div <= ext_act_q ? `ACC_NULL_DIV : 16'h0000; // RULE6
      end
   end

   // ==========================================================
   // address formation
   logic [1:0] tri_idx;
   logic dual_bit;
   logic [6:0] my_addr;

   assign tri_idx = (lvl_q[1:0] == 2'h3) ? 2'h2 : lvl_q[1:0]; // RULE4
   assign dual_bit = ext_act_q | ~lvl_q[I_FLT]; // RULE5 RULE6
   assign my_addr = ADDR_BASE | {4'h0, tri_idx, dual_bit};

   // ==========================================================
   // serial slave shifter
   acc_pkg::acc_phase_e phase_q;
   acc_pkg::acc_bus_e bus_q;
   logic [3:0] bit_q;
   logic [7:0] rx_q;
   logic [7:0] tx_q;
   logic [1:0] byte_q;
   logic rw_q;
   logic mack_q;
   logic wr_valid_q;
   logic [7:0] cfg_new_q;
   logic addr_ack;
   logic rd_done;
   logic pop;
   logic [7:0] fifo_dout;
   logic fifo_ov;
   logic [7:0] tx_next;

   assign addr_ack = scl_fall && bit_q == 4'h8 && bus_q == acc_pkg::BS_ADDR &&
                     rx_q[7:1] == my_addr && phase_q != acc_pkg::PH_CONV; // RULE9 RULE24
   assign rd_done = scl_fall && bit_q == 4'h8 && bus_q == acc_pkg::BS_READ &&
                    byte_q == `ACC_RD_BYTES - 2'h1; // RULE13
   assign pop = scl_fall && bit_q == 4'h9 &&
                ((bus_q == acc_pkg::BS_ADDR && rw_q) ||
                 (bus_q == acc_pkg::BS_READ && mack_q && byte_q < `ACC_RD_BYTES - 2'h1));
   assign tx_next = fifo_ov ? fifo_dout : 8'hFF;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bus_q <= acc_pkg::BS_IDLE;
         bit_q <= 4'h0;
         rx_q <= 8'h00;
         tx_q <= 8'hFF;
         byte_q <= 2'h0;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         wr_valid_q <= 1'b0;
         cfg_new_q <= `ACC_CFG_DEFAULT;
         sda_oe_b <= 1'b1;
         sda_out <= 1'b0;
      end
      else if (stop_ev)
      begin
         bus_q <= acc_pkg::BS_IDLE;
         wr_valid_q <= 1'b0;
         sda_oe_b <= 1'b1;
      end
      else if (start_ev)
      begin
         bus_q <= acc_pkg::BS_ADDR; // RULE15
         bit_q <= 4'h0;
         wr_valid_q <= 1'b0;
         sda_oe_b <= 1'b1;
      end
      else if (scl_rise && bus_q != acc_pkg::BS_IDLE && bus_q != acc_pkg::BS_IGNORE)
      begin
         if (bit_q < 4'h8)
         begin
            rx_q <= {rx_q[6:0], sda}; // RULE2 RULE12
         end
         else
         begin
            mack_q <= ~sda; // RULE17
         end
         bit_q <= bit_q + 4'h1; // RULE16
      end
      else if (scl_fall && bus_q != acc_pkg::BS_IDLE && bus_q != acc_pkg::BS_IGNORE)
      begin
         if (bit_q == 4'h8)
         begin
            unique case (bus_q)
               acc_pkg::BS_ADDR:
               begin
                  if (addr_ack)
                  begin
                     sda_oe_b <= 1'b0; // RULE17 RULE24
                     rw_q <= rx_q[0];
                  end
                  else
                  begin
                     bus_q <= acc_pkg::BS_IGNORE; // RULE9
                  end
               end
               acc_pkg::BS_WRITE:
               begin
                  if (byte_q == 2'h0)
                  begin
                     cfg_new_q <= rx_q; // RULE12
                     wr_valid_q <= 1'b1;
                     sda_oe_b <= 1'b0;
                  end
               end
               acc_pkg::BS_READ,
               acc_pkg::BS_IDLE,
               acc_pkg::BS_IGNORE:
               begin
                  sda_oe_b <= 1'b1; // RULE17
               end
            endcase
         end
         else if (bit_q == 4'h9)
         begin
            bit_q <= 4'h0;
            sda_oe_b <= 1'b1;
            if (pop)
            begin
               bus_q <= acc_pkg::BS_READ; // RULE24
               byte_q <= (bus_q == acc_pkg::BS_ADDR) ? 2'h0 : byte_q + 2'h1;
               tx_q <= tx_next;
               sda_oe_b <= tx_next[7]; // RULE2 RULE3
            end
            else if (bus_q == acc_pkg::BS_ADDR)
            begin
               bus_q <= acc_pkg::BS_WRITE;
               byte_q <= 2'h0;
            end
            else if (bus_q == acc_pkg::BS_WRITE)
            begin
               byte_q <= 2'h1;
            end
            else
            begin
               bus_q <= acc_pkg::BS_IGNORE;
            end
         end
         else if (bus_q == acc_pkg::BS_READ && bit_q != 4'h0)
         begin
            sda_oe_b <= tx_q[3'h7 - bit_q[2:0]]; // RULE2 RULE3 RULE18
         end
      end
   end

   // ==========================================================
   // conversion cycle
   logic [7:0] cfg_q;
   logic [7:0] cfg_conv_q;
   logic [15:0] conv_cnt_q;
   logic [15:0] conv_len;
   logic conv_done;
   logic start_conv;
   logic wr_stop;
   logic [23:0] res_q;
   logic [16:0] code;
   acc_pkg::acc_phase_e phase_d;

   assign conv_len = cfg_conv_q[`ACC_CFG_DBL] ? CONV_2X_TICKS : CONV_1X_TICKS; // RULE23
   assign conv_done = phase_q == acc_pkg::PH_CONV && conv_tick &&
                      conv_cnt_q == conv_len - 16'h0001;
   assign wr_stop = stop_ev && wr_valid_q && bus_q == acc_pkg::BS_WRITE;
   assign start_conv = wr_stop || rd_done; // RULE13
   assign code = adc_over ? `ACC_OVR_CODE : (adc_under ? `ACC_UND_CODE : adc_code); // RULE20

   always_comb
   begin
      phase_d = phase_q;
      unique case (phase_q)
         acc_pkg::PH_CONV:
         begin
            if (conv_done)
            begin
               phase_d = acc_pkg::PH_SLEEP; // RULE7
            end
         end
         acc_pkg::PH_SLEEP:
         begin
            if (addr_ack)
            begin
               phase_d = acc_pkg::PH_IO; // RULE8
            end
         end
         acc_pkg::PH_IO:
         begin
            if (start_conv)
            begin
               phase_d = acc_pkg::PH_CONV; // RULE7 RULE13
            end
            else if (stop_ev)
            begin
               phase_d = acc_pkg::PH_SLEEP;
            end
         end
         default:
         begin
            phase_d = acc_pkg::PH_CONV;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase_q <= acc_pkg::PH_CONV;
         conv_active <= 1'b1;
         sleep_active <= 1'b0;
         conv_cnt_q <= 16'h0000;
      end
      else
      begin
         phase_q <= phase_d;
         conv_active <= (phase_d == acc_pkg::PH_CONV);
         sleep_active <= (phase_d == acc_pkg::PH_SLEEP);
         if (phase_q != acc_pkg::PH_CONV)
         begin
            conv_cnt_q <= 16'h0000;
         end
         else if (conv_tick)
         begin
            conv_cnt_q <= conv_cnt_q + 16'h0001; // RULE23
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_q <= `ACC_CFG_DEFAULT; // RULE22
         cfg_conv_q <= `ACC_CFG_DEFAULT;
         res_q <= 24'h000000;
      end
      else
      begin
         if (wr_stop)
         begin
            cfg_q <= cfg_new_q; // RULE22
         end
         if (start_conv)
         begin
            cfg_conv_q <= wr_stop ? cfg_new_q : cfg_q;
         end
         if (conv_done)
         begin
            // readback omits the reserved bit so the frame stays 24 bits
            res_q <= {code, cfg_conv_q[`ACC_CFG_GS_HI:`ACC_CFG_GS_LO],
                      cfg_conv_q[`ACC_CFG_TEMP:`ACC_CFG_DBL]}; // RULE10 RULE21
         end
      end
   end

   assign gain_sel = cfg_conv_q[`ACC_CFG_GS_HI:`ACC_CFG_GS_LO]; // RULE21
   assign temp_input_select = cfg_conv_q[`ACC_CFG_TEMP];
   assign reject_mode_hi = cfg_conv_q[`ACC_CFG_REJ_HI];
   assign reject_mode_lo = cfg_conv_q[`ACC_CFG_REJ_LO];
   assign double_rate_select = cfg_conv_q[`ACC_CFG_DBL];

   // ==========================================================
   // result bytes into the buffer
   logic [1:0] load_q;
   logic flush;
   logic push_ok;
   logic load_valid;
   logic [7:0] load_byte;

   // reload on each start and after each conversion, so no stale result leaks out
   assign flush = start_ev | conv_done; // RULE11
   assign load_valid = ~flush && load_q < `ACC_RD_BYTES && phase_q != acc_pkg::PH_CONV;
   assign load_byte = (load_q == 2'h0) ? res_q[23:16] :
                      ((load_q == 2'h1) ? res_q[15:8] : res_q[7:0]);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         load_q <= 2'h0;
      end
      else if (flush)
      begin
         load_q <= 2'h0;
      end
      else if (load_valid && push_ok)
      begin
         load_q <= load_q + 2'h1;
      end
   end

   acc_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .flush(flush),
      .in_valid(load_valid),
      .in_ready(push_ok),
      .in_data(load_byte),
      .out_valid(fifo_ov),
      .out_ready(pop),
      .out_data(fifo_dout)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   no_ack_conv_a: assert property ( // RULE9
      (scl_fall && bit_q == 4'h8 && bus_q == acc_pkg::BS_ADDR && phase_q == acc_pkg::PH_CONV)
      |=> sda_oe_b && bus_q == acc_pkg::BS_IGNORE)
      else $error("address acknowledged during conversion");
   write_stop_conv_a: assert property ( // RULE13
      (wr_stop && phase_q == acc_pkg::PH_IO) |=> conv_active && conv_cnt_q == 16'h0000)
      else $error("no conversion after write and stop");
   read_done_conv_a: assert property ( // RULE13
      rd_done |=> phase_q == acc_pkg::PH_CONV ##1 sda_oe_b)
      else $error("no conversion after full read");
   cfg_hold_a: assert property ( // RULE22
      $changed(cfg_q) |-> $past(stop_ev && wr_valid_q))
      else $error("configuration changed without valid write");
   sleep_hold_a: assert property ( // RULE8
      (phase_q == acc_pkg::PH_SLEEP && $past(phase_q) == acc_pkg::PH_SLEEP) |-> $stable(res_q))
      else $error("result changed while asleep");
   sda_on_fall_a: assert property ( // RULE2
      $changed(sda_oe_b) |-> $past(scl_fall || start_ev || stop_ev))
      else $error("data line changed outside clock low");
   ext_addr_a: assert property ( // RULE6
      ext_act_q |-> my_addr[0] && ext_null_div == `ACC_NULL_DIV || $rose(ext_act_q))
      else $error("external clock address bit not forced");
   over_code_a: assert property ( // RULE20
      (conv_done && adc_over) |=> res_q[23:7] == `ACC_OVR_CODE ##1 sleep_active)
      else $error("overrange code missing");
   sync_agree_a: assert property ( // RULE25
      $changed(lvl_q[I_SDA]) |-> $past(s2_q[I_SDA] == s3_q[I_SDA]))
      else $error("data level taken before stages agree");
   start_seen_a: assert property ( // RULE14
      (start_ev && !stop_ev) |=> bus_q == acc_pkg::BS_ADDR && bit_q == 4'h0)
      else $error("start not detected");

endmodule

/* File: design/acc_fifo.sv */
// byte buffer between the held result and the serial shifter
// assumes DEPTH is a power of two; flush empties it in one cycle
module acc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic flush,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_q[rd_q];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else if (flush)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

/* File: design/acc_map.svh */
// offsets, field positions, reset values and timing counts of the cycle control
// assumes a 20 MHz system clock and MSB-first configuration byte
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ==========================================================
// timing
`define ACC_CLK_KHZ 32'h00004E20
`define ACC_EXT_MIN_KHZ 32'h0000000A
`define ACC_EXT_WIN_CYC (`ACC_CLK_KHZ / `ACC_EXT_MIN_KHZ)
`define ACC_INT_OSC_KHZ 32'h00000133
`define ACC_INT_TICK_DIV (`ACC_CLK_KHZ / `ACC_INT_OSC_KHZ)
`define ACC_CONV_1X 16'hA04C
`define ACC_CONV_2X 16'h504C
`define ACC_NULL_DIV 16'h1400

// ==========================================================
// configuration byte fields
`define ACC_CFG_GS_HI 7
`define ACC_CFG_GS_LO 5
`define ACC_CFG_RSV 4
`define ACC_CFG_TEMP 3
`define ACC_CFG_REJ_HI 2
`define ACC_CFG_REJ_LO 1
`define ACC_CFG_DBL 0
`define ACC_CFG_DEFAULT 8'h00

// ==========================================================
// result codes, address and pin sampling
`define ACC_OVR_CODE 17'h1FFFF
`define ACC_UND_CODE 17'h00000
`define ACC_ADDR_BASE 7'h10
`define ACC_RD_BYTES 2'h3
`define ACC_SYNC_RST 6'h30

`endif

/* File: design/acc_pkg.sv */
// types used only by the cycle control, not by its helpers
// assumes nothing of its surroundings
package acc_pkg;

   typedef enum logic [1:0] {PH_CONV, PH_SLEEP, PH_IO} acc_phase_e;

   typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_WRITE, BS_READ, BS_IGNORE} acc_bus_e;

endpackage

/* File: test/acc_ctrl_tb_top.sv */
// self-checking bench of the cycle control driven by a bus master model
// assumes acc_ctrl and acc_i2c_master are compiled before it
module acc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, scl, sda_m, sda_w, sda_out, sda_oe_b;
   logic [1:0] tri_pin;
   logic dual_pin, dual_flt, adc_over, adc_under;
   logic [16:0] adc_code;
   logic conv_active, sleep_active, ext_act, filt_tick;
   logic [15:0] null_div;
   wire [6:0] cfg_o;
   int fail_count, n_tests;
   // open-drain data wire with pull-up
   assign sda_w = sda_m & (sda_oe_b | sda_out);
   acc_ctrl #(.CONV_1X_TICKS(16'h0100), .CONV_2X_TICKS(16'h0080), .INT_TICK_DIV(8'h02))
   u_acc_ctrl
   (
      .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_b(sda_oe_b), .addr_sel_tristate_pin(tri_pin),
      .addr_sel_or_ext_clock_pin(dual_pin), .addr_sel_or_ext_clock_float(dual_flt),
      .adc_code(adc_code), .adc_over(adc_over), .adc_under(adc_under),
      .conv_active(conv_active), .sleep_active(sleep_active), .ext_clk_active(ext_act),
      .filt_tick(filt_tick), .ext_null_div(null_div), .gain_sel(cfg_o[6:4]),
      .temp_input_select(cfg_o[3]), .reject_mode_hi(cfg_o[2]),
      .reject_mode_lo(cfg_o[1]), .double_rate_select(cfg_o[0])
   );
   acc_i2c_master u_acc_i2c_master
   (
      .clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_m)
   );
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ==========================================================
   // checking and closing
   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // bus helpers
   task automatic addr(input logic [6:0] a, input logic rd, input logic exp);
      logic [7:0] q;
      logic k;
      u_acc_i2c_master.start();
      u_acc_i2c_master.xbyte({a, rd}, 1'b1, q, k);
      chk("addr ack", k, exp);
   endtask
   task automatic stop_conv(input logic exp);
      u_acc_i2c_master.stop();
      chk("converting", conv_active, exp);
   endtask
   task automatic wait_sleep();
      int n;
      n = 0;
      while (sleep_active !== 1'b1 && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      chk("sleep", sleep_active, 1'b1);
   endtask
   task automatic read3(input logic rs, input logic [23:0] exp);
      logic [23:0] got;
      logic k;
      wait_sleep();
      if (rs)
         addr(7'h13, 1'b0, 1'b0);
      addr(7'h13, 1'b1, 1'b0);
      u_acc_i2c_master.xbyte(8'hFF, 1'b0, got[23:16], k);
      u_acc_i2c_master.xbyte(8'hFF, 1'b0, got[15:8], k);
      u_acc_i2c_master.xbyte(8'hFF, 1'b1, got[7:0], k);
      chk("result", got, exp);
      stop_conv(1'b1);
   endtask
   // ==========================================================
   // scenarios
   task automatic s_busy();
      addr(7'h13, 1'b0, 1'b1);
      stop_conv(1'b1);
      wait_sleep();
      repeat (200) @(posedge clk);
      chk("sleep held", sleep_active, 1'b1);
   endtask
   task automatic s_addr();
      for (int i = 0; i < 3; i++)
      begin
         tri_pin <= 2'(i);
         addr({4'h2, 2'(i), 1'b1}, 1'b0, 1'b0);
         stop_conv(1'b0);
      end
      tri_pin <= 2'h1;
      dual_flt <= 1'b1;
      addr(7'h13, 1'b0, 1'b1);
      stop_conv(1'b0);
      addr(7'h12, 1'b0, 1'b0);
      stop_conv(1'b0);
      dual_flt <= 1'b0;
   endtask
   task automatic s_ext();
      int t;
      fork
         repeat (100)
         begin
            repeat (10) @(posedge clk);
            dual_pin <= ~dual_pin;
         end
         begin
            dual_flt <= 1'b1;
            repeat (100) @(posedge clk);
            chk("ext clock", ext_act, 1'b1);
            chk("null divider", null_div, 16'h1400);
            // one conversion tick per rising edge of the external clock
            t = 0;
            repeat (200)
            begin
               @(posedge clk);
               if (filt_tick === 1'b1)
                  t++;
            end
            chk("ext ticks", 24'(t), 24'h00000A);
            addr(7'h13, 1'b0, 1'b0);
            stop_conv(1'b0);
            dual_flt <= 1'b0;
         end
      join
      repeat (2100) @(posedge clk);
      chk("ext clock", ext_act, 1'b0);
   endtask
   task automatic s_write();
      logic [7:0] q;
      logic k;
      int n;
      u_acc_i2c_master.hp = 30;
      addr(7'h13, 1'b0, 1'b0);
      u_acc_i2c_master.xbyte(8'hAB, 1'b1, q, k);
      chk("cfg ack", k, 1'b0);
      u_acc_i2c_master.xbyte(8'h55, 1'b1, q, k);
      chk("extra byte ack", k, 1'b1);
      adc_code <= 17'h12345;
      stop_conv(1'b1);
      u_acc_i2c_master.hp = 8;
      chk("cfg", cfg_o, 7'h5B);
      n = 0;
      while (conv_active === 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      chk("conv length", n > 200 && n <= 256, 1'b1);
   endtask
   task automatic s_read();
      adc_over <= 1'b1;
      read3(1'b0, {8'h91, 8'hA2, 8'hDB});
      // let the overrange conversion finish before the flags move
      wait_sleep();
      adc_over <= 1'b0;
      adc_under <= 1'b1;
      read3(1'b0, {16'hFFFF, 8'hDB});
      read3(1'b1, {16'h0000, 8'h5B});
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      rst_b = 1'b0;
      tri_pin = 2'h1;
      dual_pin = 1'b1;
      dual_flt = 1'b0;
      adc_code = 17'h00000;
      adc_over = 1'b0;
      adc_under = 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("converting", conv_active, 1'b1);
      chk("released", sda_oe_b, 1'b1);
      chk("cfg", cfg_o, 7'h00);
      s_busy();
      s_addr();
      s_ext();
      s_write();
      s_read();
      conclude();
   end
   initial
   begin
      repeat (40000) @(posedge clk);
      fail_count++;
      conclude();
   end
endmodule

/* File: test/acc_i2c_master.sv */
// two-wire bus master model that drives the serial clock and data lines
// assumes the bench resolves the open-drain data wire with a pull-up
module acc_i2c_master
(
   // clock
   input wire logic clk,
   // bus lines
   input wire logic sda_w,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // third of a bit time in clk cycles, raised by the bench for slow masters
   int hp = 8;
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic wt();
      repeat (hp) @(posedge clk);
   endtask
   // start or repeated start, entered with the clock high or low
   task automatic start();
      wt();
      sda <= 1'b1;
      wt();
      scl <= 1'b1;
      wt();
      sda <= 1'b0;
      wt();
      scl <= 1'b0;
   endtask
   task automatic stop();
      wt();
      sda <= 1'b0;
      wt();
      scl <= 1'b1;
      wt();
      sda <= 1'b1;
      wt();
   endtask
   task automatic xbit(input logic b, output logic r);
      wt();
      sda <= b;
      wt();
      scl <= 1'b1;
      wt();
      r = sda_w;
      scl <= 1'b0;
   endtask
   // eight data bits then the acknowledge bit; 1 releases the line
   task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic nak);
      for (int i = 7; i >= 0; i--)
      begin
         xbit(d[i], q[i]);
      end
      xbit(ak, nak);
   endtask
endmodule
